// *** rtl/hvcfg_link_shift.sv ***
/*
 * Link shift register for the companion die interface.
 * Assumes the framing logic outside supplies the link clock, the frame
 * level and serial input; all three are asynchronous to i_clk and are
 * synchronised here before use.
 */
`timescale 1ns/10ps

module hvcfg_link_shift (
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  input  wire logic       i_start,
  input  wire logic [7:0] i_tx_byte,
  input  wire logic       i_link_clk,
  input  wire logic       i_link_sdi,
  input  wire logic       i_link_frame,
  output logic      [7:0] o_shift,
  output logic            o_sdo,
  output logic            o_busy,
  output logic            o_done
);

  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic [1:0] prev_reg;
  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic       busy_reg;
  logic       busy_next;
  wire        clk_s   = sync2_reg[0];
  wire        frame_s = sync2_reg[1];
  wire        sdi_s   = sync2_reg[2];
  wire        clk_rise  = clk_s & ~prev_reg[0] & frame_s;
  wire        frame_end = prev_reg[1] & ~frame_s;

  //////////////////////////////////////////////////////////////////////////////
  // Synchronisers; first stage feeds only the second

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
      prev_reg  <= 2'h0;
    end else begin
      sync1_reg <= {i_link_sdi, i_link_frame, i_link_clk};
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg[1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Shifter: MSB out, sample in on each link clock rise inside a frame

  assign o_done     = frame_end & busy_reg;
  assign shift_next = i_start  ? i_tx_byte :
                      clk_rise ? {shift_reg[6:0], sdi_s} : shift_reg;
  assign busy_next  = i_start | (busy_reg & ~frame_end);

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      shift_reg <= 8'h00;
      busy_reg  <= 1'b0;
    end else begin
      shift_reg <= shift_next;
      busy_reg  <= busy_next;
    end
  end

  assign o_shift = shift_reg;
  assign o_sdo   = shift_reg[7];
  assign o_busy  = busy_reg;

endmodule

// *** rtl/hvcfg_pkg.sv ***
/*
 * Constants and types shared by the high-voltage die register bank and
 * its die model and port checker: register addresses, field positions, command codes,
 * reset values and interrupt bit positions.
 * Assumes a 32-bit byte address bus and a 40 MHz system clock.
 */
package hvcfg_pkg;

  // Register byte addresses
  localparam logic [31:0] ADDR_COMMAND  = 32'h4000_3004;
  localparam logic [31:0] ADDR_KEYHOLE  = 32'h4000_300C;
  localparam logic [31:0] ADDR_CONFIG   = 32'h4000_3010;
  localparam logic [31:0] ADDR_IRQ_STS  = 32'h4000_3020;
  localparam logic [31:0] ADDR_IRQ_MASK = 32'h4000_3024;

  // Keyhole data fields
  localparam int KEY_DATA_LSB = 0;
  localparam int KEY_COM_LSB  = 8;

  // Configuration shadow bit positions
  localparam int CFG_LIN_EN      = 0;
  localparam int CFG_SHORT_OFF   = 1;
  localparam int CFG_REENABLE    = 2;
  localparam int CFG_ATTEN_DIAG  = 3;
  localparam int CFG_LOWVOLT_EN  = 4;
  localparam logic [7:0] CFG_WRITABLE = 8'h1F;

  // Command register read bits
  localparam int CMD_BUSY_BIT     = 0;
  localparam int CMD_MIRROR_BUSY  = 3;

  // Link command codes
  localparam logic [3:0] CMD_READ_CONFIG  = 4'h0;
  localparam logic [3:0] CMD_READ_STATUS  = 4'h2;
  localparam logic [3:0] CMD_WRITE_CONFIG = 4'h8;

  // Reset values
  localparam logic [7:0] KEY_DATA_RST = 8'h00;
  localparam logic [3:0] KEY_COM_RST  = 4'h0;
  localparam logic [7:0] CFG_RST      = 8'h00;
  localparam logic [2:0] IRQ_RST      = 3'h0;

  // Interrupt status bit positions
  localparam int IRQ_XFER_DONE = 0;
  localparam int IRQ_HV_EVENT  = 1;
  localparam int IRQ_SHORT     = 2;

  // Mirror sequencer states, Gray coded along idle, write, readback
  typedef enum logic [1:0] {
    HVCFG_IDLE = 2'b00,
    HVCFG_WR   = 2'b01,
    HVCFG_RB   = 2'b11,
    HVCFG_KEY  = 2'b10
  } hvcfg_state_e;

  // One request toward the companion die
  typedef struct packed {
    logic [3:0] cmd;
    logic [7:0] data;
  } hvcfg_link_req_s;

endpackage

// *** rtl/hvcfg_regs.sv ***
/*
 * Low-voltage side register bank for the high-voltage companion die:
 * keyhole data register, command write port, shadowed configuration
 * register with mirror sequencer, LIN driver control and interrupts.
 * Assumes a single-cycle register port with read data one cycle later,
 * and outside framing logic that runs frames when o_link_start pulses.
 */
// How it works
// - The low byte of the keyhole data register holds the last byte exchanged with the die.
// - Bits 11 to 8 of the keyhole data register echo the last command code written.
// - The keyhole low byte follows the link shift register during every transfer.
// - An eight-bit configuration copy mirrors the die's bit layout and resets to zero.
// - Configuration bit 4 enables the low-voltage flag.
// - Configuration bit 3 switches on the attenuator diagnostic.
// - Writing one to configuration bit 2 re-enables the shorted driver and then self-clears.
// - With configuration bit 1 low a detected short shuts the LIN driver off.
// - With configuration bit 1 high the driver stays on but the short flag and interrupt still rise.
// - Configuration bit 0 enables the LIN transceiver.
// - A configuration write launches a remote write and then reloads the copy from a readback.
// - Command 0x08 writes the keyhole byte out; commands 0x00 and 0x02 read config and status back.
// - A high-voltage interrupt copies the status contents into the keyhole data register.
`timescale 1ns/10ps

module hvcfg_regs (
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic [31:0] i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  input  wire logic        i_link_clk,
  input  wire logic        i_link_sdi,
  input  wire logic        i_link_frame,
  input  wire logic        i_hv_irq,
  input  wire logic        i_short_detect,
  input  wire logic [7:0]  i_hv_status,
  output logic             o_link_start,
  output logic      [3:0]  o_link_cmd,
  output logic             o_link_sdo,
  output logic             o_lin_xcvr_en,
  output logic             o_short_protect_off,
  output logic             o_driver_reenable,
  output logic             o_attenuator_diag_enable,
  output logic             o_lowvolt_flag_enable,
  output logic             o_irq
);

  //////////////////////////////////////////////////////////////////////////////
  // Declarations

  hvcfg_pkg::hvcfg_state_e    state_reg;
  hvcfg_pkg::hvcfg_state_e    state_next;
  hvcfg_pkg::hvcfg_link_req_s req;
  logic [7:0]  key_data_reg;
  logic [7:0]  key_data_next;
  logic [3:0]  key_com_reg;
  logic [3:0]  key_com_next;
  logic [7:0]  cfg_reg;
  logic [7:0]  cfg_next;
  logic        pend_reg;
  logic        pend_next;
  logic [3:0]  cmd_out_reg;
  logic        drv_off_reg;
  logic        drv_off_next;
  logic        lin_en_reg;
  logic        reenable_reg;
  logic [1:0]  pin_sync1_reg;
  logic [1:0]  pin_sync2_reg;
  logic [1:0]  pin_prev_reg;
  logic [2:0]  irq_sts_reg;
  logic [2:0]  irq_sts_next;
  logic [2:0]  irq_mask_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [7:0]  shift;
  logic        link_busy;
  logic        link_done;

  //////////////////////////////////////////////////////////////////////////////
  // Register decode

  wire wr_cmd  = i_wr & (i_addr == hvcfg_pkg::ADDR_COMMAND);
  wire wr_key  = i_wr & (i_addr == hvcfg_pkg::ADDR_KEYHOLE);
  wire wr_cfg  = i_wr & (i_addr == hvcfg_pkg::ADDR_CONFIG);
  wire wr_ists = i_wr & (i_addr == hvcfg_pkg::ADDR_IRQ_STS);
  wire wr_imsk = i_wr & (i_addr == hvcfg_pkg::ADDR_IRQ_MASK);

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers for the die interrupt and short detect

  wire hv_irq_s    = pin_sync2_reg[0];
  wire short_s     = pin_sync2_reg[1];
  wire hv_irq_rise = hv_irq_s & ~pin_prev_reg[0];
  wire short_rise  = short_s & ~pin_prev_reg[1];

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pin_sync1_reg <= 2'h0;
      pin_sync2_reg <= 2'h0;
      pin_prev_reg  <= 2'h0;
    end else begin
      pin_sync1_reg <= {i_short_detect, i_hv_irq};
      pin_sync2_reg <= pin_sync1_reg;
      pin_prev_reg  <= pin_sync2_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Mirror sequencer and link launch

  wire idle      = (state_reg == hvcfg_pkg::HVCFG_IDLE);
  // Pending mirror writes win over keyhole commands; a command issued
  // while anything is in flight is dropped, as software must poll busy
  wire start_cfg = idle & pend_reg;
  wire start_key = idle & wr_cmd & ~pend_reg;
  wire start_rb  = (state_reg == hvcfg_pkg::HVCFG_WR) & link_done;
  wire mir_busy  = pend_reg | (state_reg == hvcfg_pkg::HVCFG_WR)
                 | (state_reg == hvcfg_pkg::HVCFG_RB);
  wire rb_cfg    = link_done & ((state_reg == hvcfg_pkg::HVCFG_RB)
                 | ((state_reg == hvcfg_pkg::HVCFG_KEY)
                 & (key_com_reg == hvcfg_pkg::CMD_READ_CONFIG)));

  assign req.cmd  = start_cfg ? hvcfg_pkg::CMD_WRITE_CONFIG :
                    start_rb  ? hvcfg_pkg::CMD_READ_CONFIG  : i_wdata[3:0];
  assign req.data = start_cfg ? cfg_reg : key_data_reg;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      hvcfg_pkg::HVCFG_IDLE: begin
        if (start_cfg) begin
          state_next = hvcfg_pkg::HVCFG_WR;
        end else if (start_key) begin
          state_next = hvcfg_pkg::HVCFG_KEY;
        end
      end
      hvcfg_pkg::HVCFG_WR: begin
        if (link_done) begin
          state_next = hvcfg_pkg::HVCFG_RB;
        end
      end
      hvcfg_pkg::HVCFG_RB,
      hvcfg_pkg::HVCFG_KEY: begin
        if (link_done) begin
          state_next = hvcfg_pkg::HVCFG_IDLE;
        end
      end
      default: begin
        state_next = hvcfg_pkg::HVCFG_IDLE;
      end
    endcase
  end

  // A write arriving while a mirror cycle runs is kept pending, but the readback overwrites the copy and that value is sent next
  assign pend_next = wr_cfg | (pend_reg & ~start_cfg);

  hvcfg_link_shift u_shift (
    .i_clk        (i_clk),
    .i_rst_b      (i_rst_b),
    .i_start      (o_link_start),
    .i_tx_byte    (req.data),
    .i_link_clk   (i_link_clk),
    .i_link_sdi   (i_link_sdi),
    .i_link_frame (i_link_frame),
    .o_shift      (shift),
    .o_sdo        (o_link_sdo),
    .o_busy       (link_busy),
    .o_done       (link_done)
  );

  assign o_link_start = start_cfg | start_key | start_rb;

  //////////////////////////////////////////////////////////////////////////////
  // Keyhole data register

  assign key_data_next = hv_irq_rise ? i_hv_status :
                         wr_key      ? i_wdata[7:0] :
                         (link_busy | link_done) ? shift : key_data_reg;
  assign key_com_next  = wr_cmd ? i_wdata[3:0] : key_com_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Configuration shadow and LIN control

  // A readback never restores the self-clearing re-enable bit
  assign cfg_next =
    wr_cfg ? (i_wdata[7:0] & hvcfg_pkg::CFG_WRITABLE) :
    rb_cfg ? (shift & hvcfg_pkg::CFG_WRITABLE & ~(8'h01 << hvcfg_pkg::CFG_REENABLE)) :
    (cfg_reg & ~(8'h01 << hvcfg_pkg::CFG_REENABLE));

  assign drv_off_next = cfg_reg[hvcfg_pkg::CFG_REENABLE] ? 1'b0 :
                        (short_s & ~cfg_reg[hvcfg_pkg::CFG_SHORT_OFF]) | drv_off_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Interrupts: set wins over a write-one clear

  assign irq_sts_next =
    (irq_sts_reg & ~(wr_ists ? i_wdata[2:0] : 3'h0))
    | ({2'h0, link_done} << hvcfg_pkg::IRQ_XFER_DONE)
    | ({2'h0, hv_irq_rise} << hvcfg_pkg::IRQ_HV_EVENT)
    | ({2'h0, short_rise} << hvcfg_pkg::IRQ_SHORT);

  //////////////////////////////////////////////////////////////////////////////
  // Read path

  always_comb begin
    rdata_next = 32'h0000_0000;
    if (i_rd) begin
      case (i_addr)
        hvcfg_pkg::ADDR_COMMAND: begin
          rdata_next[hvcfg_pkg::CMD_BUSY_BIT]    = link_busy;
          rdata_next[hvcfg_pkg::CMD_MIRROR_BUSY] = mir_busy;
        end
        hvcfg_pkg::ADDR_KEYHOLE: begin
          rdata_next[hvcfg_pkg::KEY_DATA_LSB +: 8] = key_data_reg;
          rdata_next[hvcfg_pkg::KEY_COM_LSB +: 4]  = key_com_reg;
        end
        hvcfg_pkg::ADDR_CONFIG: begin
          rdata_next[7:0] = cfg_reg;
        end
        hvcfg_pkg::ADDR_IRQ_STS: begin
          rdata_next[2:0] = irq_sts_reg;
        end
        hvcfg_pkg::ADDR_IRQ_MASK: begin
          rdata_next[2:0] = irq_mask_reg;
        end
        default: begin
          rdata_next = 32'h0000_0000;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // State registers

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg    <= hvcfg_pkg::HVCFG_IDLE;
      pend_reg     <= 1'b0;
      cmd_out_reg  <= hvcfg_pkg::KEY_COM_RST;
      key_data_reg <= hvcfg_pkg::KEY_DATA_RST;
      key_com_reg  <= hvcfg_pkg::KEY_COM_RST;
      cfg_reg      <= hvcfg_pkg::CFG_RST;
      drv_off_reg  <= 1'b0;
      lin_en_reg   <= 1'b0;
      reenable_reg <= 1'b0;
      irq_sts_reg  <= hvcfg_pkg::IRQ_RST;
      irq_mask_reg <= hvcfg_pkg::IRQ_RST;
      rdata_reg    <= 32'h0000_0000;
    end else begin
      state_reg    <= state_next;
      pend_reg     <= pend_next;
      cmd_out_reg  <= o_link_start ? req.cmd : cmd_out_reg;
      key_data_reg <= key_data_next;
      key_com_reg  <= key_com_next;
      cfg_reg      <= cfg_next;
      drv_off_reg  <= drv_off_next;
      lin_en_reg   <= cfg_reg[hvcfg_pkg::CFG_LIN_EN] & ~drv_off_next;
      reenable_reg <= cfg_reg[hvcfg_pkg::CFG_REENABLE];
      irq_sts_reg  <= irq_sts_next;
      irq_mask_reg <= wr_imsk ? i_wdata[2:0] : irq_mask_reg;
      rdata_reg    <= rdata_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign o_rdata                  = rdata_reg;
  assign o_link_cmd               = cmd_out_reg;
  assign o_lin_xcvr_en            = lin_en_reg;
  assign o_short_protect_off      = cfg_reg[hvcfg_pkg::CFG_SHORT_OFF];
  assign o_driver_reenable        = reenable_reg;
  assign o_attenuator_diag_enable = cfg_reg[hvcfg_pkg::CFG_ATTEN_DIAG];
  assign o_lowvolt_flag_enable    = cfg_reg[hvcfg_pkg::CFG_LOWVOLT_EN];
  assign o_irq                    = |(irq_sts_reg & irq_mask_reg);

endmodule

// *** verif/hv_die_data_and_config_regs_tb.sv ***
/* Self-checking bench for the companion die register bank.
   Assumes the die model and the bound port checker. */
`timescale 1ns/10ps
module hv_die_data_and_config_regs_tb;
  localparam logic [31:0] A_CMD = hvcfg_pkg::ADDR_COMMAND;
  localparam logic [31:0] A_KEY = hvcfg_pkg::ADDR_KEYHOLE;
  localparam logic [31:0] A_CFG = hvcfg_pkg::ADDR_CONFIG;
  localparam logic [31:0] A_STS = hvcfg_pkg::ADDR_IRQ_STS;
  localparam logic [31:0] A_MSK = hvcfg_pkg::ADDR_IRQ_MASK;
  logic        i_clk = 1'b0;
  logic        i_rst_b;
  logic [31:0] i_addr;
  logic [31:0] i_wdata;
  logic        i_wr;
  logic        i_rd;
  logic [31:0] o_rdata;
  logic        lclk;
  logic        lsdi;
  logic        lframe;
  logic        hv_irq;
  logic        short_det;
  logic [7:0]  hv_status;
  logic        lstart;
  logic [3:0]  lcmd;
  logic        lsdo;
  logic        lin_en;
  logic        prot_off;
  logic        atten;
  logic        lowvolt;
  logic        irq;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  integer      seed;
  logic [31:0] d;
  always #12.5 i_clk = ~i_clk;

  hvcfg_regs i_hvcfg_regs (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_link_clk(lclk), .i_link_sdi(lsdi),
    .i_link_frame(lframe), .i_hv_irq(hv_irq), .i_short_detect(short_det),
    .i_hv_status(hv_status), .o_link_start(lstart), .o_link_cmd(lcmd), .o_link_sdo(lsdo),
    .o_lin_xcvr_en(lin_en), .o_short_protect_off(prot_off), .o_driver_reenable(),
    .o_attenuator_diag_enable(atten), .o_lowvolt_flag_enable(lowvolt), .o_irq(irq));
  hvcfg_die_model i_hvcfg_die_model (
    .i_clk(i_clk), .i_start(lstart), .i_cmd(lcmd), .i_sdo(lsdo), .i_status(hv_status),
    .o_link_clk(lclk), .o_sdi(lsdi), .o_frame(lframe));
  ////////////////////////////////////////
  function automatic logic [31:0] cfg_back(input logic [31:0] w);
    return {24'h0, w[7:0] & 8'h1B};
  endfunction
  function automatic logic [31:0] key_exp(input logic [3:0] c, input logic [7:0] v);
    return {20'h0, c, v};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] v);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    v = o_rdata;
  endtask
  task automatic rc(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd(a, v);
    chk(v, exp);
  endtask
  task automatic pin(input logic p, input logic exp);
    chk({31'h0, p}, {31'h0, exp});
  endtask
  task automatic wait_idle;
    logic [31:0] v;
    int n;
    n = 0;
    repeat (4) @(posedge i_clk);
    do begin
      rd(A_CMD, v);
      n++;
    end while ((v[0] !== 1'b0 || v[3] !== 1'b0) && n < 500);
    if (n >= 500) n_mismatch++;
  endtask
  task automatic close_out;
    $display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    #300000;
    n_mismatch++;
    close_out;
  end
  initial begin
    seed = 32'h3B53;
    i_rst_b = 1'b0;
    i_addr = 32'h0;
    i_wdata = 32'h0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    hv_irq = 1'b0;
    short_det = 1'b0;
    hv_status = 8'h00;
    repeat (20) @(posedge i_clk);
    i_rst_b <= 1'b1;
    rc(A_CFG, 32'h0);
    rc(A_KEY, 32'h0);
    rc(32'h4000_3000, 32'h0);
    for (int i = 0; i < 6; i++) begin
      d = (i == 0) ? 32'hFFFF_FFFF : (i == 1) ? 32'h0 : $random(seed);
      wr(A_CFG, d);
      repeat (2) @(negedge i_clk);
      chk({28'h0, lowvolt, atten, prot_off, lin_en}, {28'h0, d[4:3], d[1:0]});
      wait_idle;
      rc(A_CFG, cfg_back(d));
    end
    d = $random(seed);
    wr(A_KEY, d);
    rc(A_KEY, key_exp(4'h0, d[7:0]));
    wr(A_CMD, 32'h8);
    wait_idle;
    wr(A_CMD, 32'h0);
    wait_idle;
    rc(A_KEY, key_exp(4'h0, d[7:0] & 8'h1B));
    rc(A_CFG, cfg_back(d));
    d = $random(seed);
    @(posedge i_clk) hv_status <= d[7:0];
    wr(A_CMD, 32'h2);
    wait_idle;
    rc(A_KEY, key_exp(4'h2, d[7:0]));
    wr(A_STS, 32'h7);
    d = $random(seed);
    @(posedge i_clk) hv_status <= d[7:0];
    @(posedge i_clk) hv_irq <= 1'b1;
    repeat (6) @(posedge i_clk);
    rc(A_KEY, key_exp(4'h2, d[7:0]));
    rc(A_STS, 32'h2);
    pin(irq, 1'b0);
    wr(A_MSK, 32'h2);
    repeat (2) @(negedge i_clk);
    pin(irq, 1'b1);
    wr(A_STS, 32'h2);
    repeat (2) @(negedge i_clk);
    pin(irq, 1'b0);
    @(posedge i_clk) hv_irq <= 1'b0;
    wr(A_CFG, 32'h1);
    wait_idle;
    @(posedge i_clk) short_det <= 1'b1;
    repeat (8) @(negedge i_clk);
    pin(lin_en, 1'b0);
    @(posedge i_clk) short_det <= 1'b0;
    repeat (8) @(negedge i_clk);
    pin(lin_en, 1'b0);
    wr(A_CFG, 32'h5);
    repeat (4) @(negedge i_clk);
    pin(lin_en, 1'b1);
    wait_idle;
    rc(A_CFG, 32'h1);
    wr(A_CFG, 32'h3);
    wait_idle;
    wr(A_STS, 32'h7);
    @(posedge i_clk) short_det <= 1'b1;
    repeat (8) @(negedge i_clk);
    pin(lin_en, 1'b1);
    rc(A_STS, 32'h4);
    wr(A_MSK, 32'h4);
    repeat (2) @(negedge i_clk);
    pin(irq, 1'b1);
    @(posedge i_clk) short_det <= 1'b0;
    close_out;
  end
endmodule

// *** verif/hvcfg_die_model.sv ***
/* Behavioural companion die: runs one frame per start pulse.
   Assumes the command is valid one clock after the start pulse. */
`timescale 1ns/10ps
module hvcfg_die_model (
  input  wire logic       i_clk,
  input  wire logic       i_start,
  input  wire logic [3:0] i_cmd,
  input  wire logic       i_sdo,
  input  wire logic [7:0] i_status,
  output logic            o_link_clk,
  output logic            o_sdi,
  output logic            o_frame
);
  logic [7:0] cfg_reg;
  logic [7:0] tx;
  logic [7:0] rx;
  logic [3:0] cmd;
  initial begin
    cfg_reg = 8'h00;
    o_link_clk = 1'b0;
    o_sdi = 1'b0;
    o_frame = 1'b0;
    forever begin
      @(posedge i_clk iff i_start);
      @(posedge i_clk);
      #1 cmd = i_cmd;
      tx = (cmd == hvcfg_pkg::CMD_READ_STATUS) ? i_status : cfg_reg;
      #50 o_frame = 1'b1;
      // Link clock runs only inside the frame, MSB first
      for (int k = 7; k >= 0; k--) begin
        o_sdi = tx[k];
        #100 o_link_clk = 1'b1;
        rx = {rx[6:0], i_sdo};
        #100 o_link_clk = 1'b0;
      end
      // Released line flips so a stale sample cannot pass
      o_sdi = ~o_sdi;
      #100 o_frame = 1'b0;
      // Re-enable bit is cleared by the die itself
      if (cmd == hvcfg_pkg::CMD_WRITE_CONFIG) cfg_reg = rx & 8'h1B;
    end
  end
endmodule

// *** verif/hvcfg_regs_props.sv ***
/* Port checker for the companion die register bank.
   Assumes config writes are spaced by a finished mirror cycle. */
`timescale 1ns/10ps
module hvcfg_regs_props (
  input wire logic        i_clk,
  input wire logic        i_rst_b,
  input wire logic [31:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic        i_short_detect,
  input wire logic        o_link_start,
  input wire logic [3:0]  o_link_cmd,
  input wire logic        o_lin_xcvr_en,
  input wire logic        o_short_protect_off,
  input wire logic        o_driver_reenable,
  input wire logic        o_attenuator_diag_enable,
  input wire logic        o_lowvolt_flag_enable
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);
  wire       cfg_wr   = i_wr && (i_addr == hvcfg_pkg::ADDR_CONFIG);
  wire [2:0] cfg_bits = {i_wdata[4:3], i_wdata[1]};
  wire [2:0] cfg_pins = {o_lowvolt_flag_enable, o_attenuator_diag_enable, o_short_protect_off};
  ////////////////////////////////////////
  AST_RDATA_IDLE: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("Read data not zero outside the answer cycle");
  AST_CFG_RSVD: assert property ((i_rd && i_addr == hvcfg_pkg::ADDR_CONFIG) |=>
    o_rdata[31:5] == 27'h0) else $error("Config read shows reserved bits");
  AST_LIN_OFF: assert property ((cfg_wr && !i_wdata[0]) |-> ##2 !o_lin_xcvr_en)
    else $error("Transceiver left on after enable cleared");
  AST_FIELDS: assert property (cfg_wr |-> ##2 cfg_pins == $past(cfg_bits, 2))
    else $error("Config pins differ from written bits");
  AST_REEN_PULSE: assert property (o_driver_reenable |=> !o_driver_reenable)
    else $error("Re-enable pulse longer than one cycle");
  AST_REEN_RISE: assert property ((cfg_wr && i_wdata[2]) |-> ##[1:3] o_driver_reenable)
    else $error("No re-enable pulse after bit 2 written");
  AST_MIRROR_START: assert property (cfg_wr |-> ##[1:2] (o_link_start ##1
    o_link_cmd == hvcfg_pkg::CMD_WRITE_CONFIG)) else $error("Config write launched no write");
  AST_SHORT_KILL: assert property ((i_short_detect && !o_short_protect_off) [*5]
    |=> !o_lin_xcvr_en) else $error("Driver still on during protected short");
  AST_SHORT_KEEP: assert property ((i_short_detect && o_short_protect_off && o_lin_xcvr_en)
    [*5] |=> o_lin_xcvr_en) else $error("Driver shut down with protection off");
endmodule

bind hvcfg_regs hvcfg_regs_props i_hvcfg_regs_props (
  .i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .i_short_detect(i_short_detect),
  .o_link_start(o_link_start), .o_link_cmd(o_link_cmd), .o_lin_xcvr_en(o_lin_xcvr_en),
  .o_short_protect_off(o_short_protect_off), .o_driver_reenable(o_driver_reenable),
  .o_attenuator_diag_enable(o_attenuator_diag_enable),
  .o_lowvolt_flag_enable(o_lowvolt_flag_enable)
);
